// ===== hw/flash_writer_pkg.sv
package flash_writer_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int BLOCK_BYTES = 128;
   localparam int INDEX_W = 7;
   localparam int BLOCK_W = ADDR_W - INDEX_W;

   localparam logic [DATA_W-1:0] CMD_MEM_READ = 8'h00;
   localparam logic [DATA_W-1:0] CMD_AUTO_PROGRAM = 8'h40;
   localparam logic [DATA_W-1:0] CMD_AUTO_ERASE = 8'h20;
   localparam logic [DATA_W-1:0] CMD_STATUS_READ = 8'h71;

   localparam logic [DATA_W-1:0] BLOCK_LOW_A = 8'h00;
   localparam logic [DATA_W-1:0] BLOCK_LOW_B = 8'h80;
   localparam logic [INDEX_W-1:0] LAST_INDEX = 7'h7F;

   localparam int BIT_ABNORMAL = 7;
   localparam int BIT_COMMAND_ERROR = 6;
   localparam int BIT_PROGRAM_ERROR = 5;
   localparam int BIT_ERASE_ERROR = 4;
   localparam int BIT_UNDEF_THREE = 3;
   localparam int BIT_UNDEF_TWO = 2;
   localparam int BIT_COUNT_EXCEEDED = 1;
   localparam int BIT_BAD_ADDRESS = 0;
   localparam logic [DATA_W-1:0] RETURN_CODE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [5:0] POLL_LOW_BITS = 6'h00;

   localparam int CLOCK_MHZ = 100;
   localparam int OSC_SETTLE_MS = 10;
   localparam int SETUP_MS = 10;
   localparam int unsigned OSC_SETTLE_CYCLES = OSC_SETTLE_MS * 1000 * CLOCK_MHZ;
   localparam int unsigned SETUP_CYCLES = SETUP_MS * 1000 * CLOCK_MHZ;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } write_event_s;

   typedef struct packed {
      logic start;
      logic erase;
      logic [BLOCK_W-1:0] block;
   } array_op_s;

   typedef enum logic [3:0] {
      ST_OSC_SETTLE,
      ST_SETUP,
      ST_MEM_READ,
      ST_CMD_WAIT,
      ST_PROG_ADDR,
      ST_PROG_DATA,
      ST_PROG_BUSY,
      ST_ERASE_CONFIRM,
      ST_ERASE_BUSY,
      ST_STATUS_CONFIRM,
      ST_STATUS_READ,
      ST_POLL
   } writer_state_e;

endpackage

// ===== hw/writer_strobe.sv
`timescale 1ns/1ps
module writer_strobe (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [flash_writer_pkg::ADDR_W-1:0] writer_address_bus,
   input wire logic [flash_writer_pkg::DATA_W-1:0] writer_data_in,
   output flash_writer_pkg::write_event_s write_event,
   output logic write_pulse,
   output logic read_enable
);

   logic writing;
   logic was_writing;
   flash_writer_pkg::write_event_s held;

   // A write is taken when the strobe ends, so data set up late still lands
   assign writing = !ce_n && !we_n;
   assign read_enable = !ce_n && !oe_n && we_n;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         was_writing <= 1'b0;
         held <= '0;
         write_event <= '0;
         write_pulse <= 1'b0;
      end else if (clk_en) begin
         was_writing <= writing;
         if (writing) begin
            held <= '{addr: writer_address_bus, data: writer_data_in};
         end
         write_pulse <= was_writing && !writing;
         if (was_writing && !writing) begin
            write_event <= held;
         end
      end
   end

endmodule

// ===== hw/flash_writer_mode.sv
`timescale 1ns/1ps
module flash_writer_mode #(
   parameter int unsigned OSC_CYCLES = flash_writer_pkg::OSC_SETTLE_CYCLES,
   parameter int unsigned SETUP_WAIT_CYCLES = flash_writer_pkg::SETUP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [flash_writer_pkg::ADDR_W-1:0] writer_address_bus,
   input wire logic [flash_writer_pkg::DATA_W-1:0] writer_data_bus_in,
   output logic [flash_writer_pkg::DATA_W-1:0] writer_data_bus_out,
   output logic writer_data_bus_oe,
   output logic [flash_writer_pkg::ADDR_W-1:0] mem_read_addr,
   input wire logic [flash_writer_pkg::DATA_W-1:0] mem_read_data,
   output flash_writer_pkg::array_op_s array_op,
   input wire logic [flash_writer_pkg::INDEX_W-1:0] block_read_index,
   output logic [flash_writer_pkg::DATA_W-1:0] block_read_data,
   input wire logic op_done,
   input wire logic op_fail,
   input wire logic op_count_exceeded,
   output logic commands_ready
);

   localparam int DW = flash_writer_pkg::DATA_W;
   localparam int IW = flash_writer_pkg::INDEX_W;

   function automatic logic valid_block_low(input logic [DW-1:0] low);
      return low == flash_writer_pkg::BLOCK_LOW_A || low == flash_writer_pkg::BLOCK_LOW_B;
   endfunction

   function automatic logic [DW-1:0] poll_byte(input logic ended, input logic normal);
      return {ended, ended && normal, flash_writer_pkg::POLL_LOW_BITS};
   endfunction

   flash_writer_pkg::write_event_s write_event;
   flash_writer_pkg::writer_state_e state;
   flash_writer_pkg::writer_state_e next_state;
   logic write_pulse;
   logic read_enable;
   logic [31:0] wait_count;
   logic [DW-1:0] block_buf [flash_writer_pkg::BLOCK_BYTES];
   logic [IW-1:0] byte_index;
   logic [IW-1:0] next_byte_index;
   logic [DW-1:0] return_code;
   logic [DW-1:0] next_return_code;
   logic op_ended;
   logic op_normal;
   logic next_op_ended;
   logic next_op_normal;
   logic addr_bad;
   logic next_addr_bad;
   logic next_start;
   logic next_erase;
   logic [flash_writer_pkg::BLOCK_W-1:0] block_addr;
   logic [flash_writer_pkg::BLOCK_W-1:0] next_block_addr;
   logic buf_write;
   logic idle_for_cmd;
   logic busy;
   logic [DW-1:0] cmd;
   logic [DW-1:0] read_byte;
   logic [DW-1:0] error_code;

   writer_strobe strobe (
      .sys_clk(sys_clk),
      .srst(srst),
      .clk_en(clk_en),
      .ce_n(ce_n),
      .oe_n(oe_n),
      .we_n(we_n),
      .writer_address_bus(writer_address_bus),
      .writer_data_in(writer_data_bus_in),
      .write_event(write_event),
      .write_pulse(write_pulse),
      .read_enable(read_enable)
   );

   assign cmd = write_event.data;
   assign busy = state == flash_writer_pkg::ST_PROG_BUSY
              || state == flash_writer_pkg::ST_ERASE_BUSY;
   // States in which a fresh first command byte is decoded
   assign idle_for_cmd = state == flash_writer_pkg::ST_MEM_READ
                      || state == flash_writer_pkg::ST_CMD_WAIT
                      || state == flash_writer_pkg::ST_POLL
                      || state == flash_writer_pkg::ST_STATUS_READ;
   assign commands_ready = state != flash_writer_pkg::ST_OSC_SETTLE
                        && state != flash_writer_pkg::ST_SETUP;
   assign error_code = (DW'(1) << flash_writer_pkg::BIT_ABNORMAL)
                     | (DW'(1) << flash_writer_pkg::BIT_COMMAND_ERROR);
   assign buf_write = write_pulse && (state == flash_writer_pkg::ST_PROG_ADDR
                                   || state == flash_writer_pkg::ST_PROG_DATA);

   always_comb begin
      next_state = state;
      next_byte_index = byte_index;
      next_return_code = return_code;
      next_op_ended = op_ended;
      next_op_normal = op_normal;
      next_addr_bad = addr_bad;
      next_block_addr = block_addr;
      next_start = 1'b0;
      next_erase = array_op.erase;
      case (state)
         flash_writer_pkg::ST_OSC_SETTLE: begin
            if (wait_count >= OSC_CYCLES - 1) begin
               next_state = flash_writer_pkg::ST_SETUP;
            end
         end
         flash_writer_pkg::ST_SETUP: begin
            if (wait_count >= SETUP_WAIT_CYCLES - 1) begin
               next_state = flash_writer_pkg::ST_MEM_READ;
            end
         end
         flash_writer_pkg::ST_PROG_ADDR: begin
            if (write_pulse) begin
               // Second cycle carries block address and byte zero
               next_block_addr = write_event.addr[flash_writer_pkg::ADDR_W-1:IW];
               next_addr_bad = !valid_block_low(write_event.addr[DW-1:0]);
               next_byte_index = IW'(1);
               next_state = flash_writer_pkg::ST_PROG_DATA;
            end
         end
         flash_writer_pkg::ST_PROG_DATA: begin
            if (write_pulse) begin
               next_byte_index = byte_index + IW'(1);
               if (byte_index == flash_writer_pkg::LAST_INDEX) begin
                  next_start = 1'b1;
                  next_erase = 1'b0;
                  next_state = flash_writer_pkg::ST_PROG_BUSY;
               end
            end
         end
         flash_writer_pkg::ST_PROG_BUSY, flash_writer_pkg::ST_ERASE_BUSY: begin
            // Writes are dropped here; the programmer keeps quiet until done
            if (op_done) begin
               next_op_ended = 1'b1;
               next_op_normal = !op_fail && !addr_bad && !op_count_exceeded;
               if (op_fail || addr_bad || op_count_exceeded) begin
                  next_return_code[flash_writer_pkg::BIT_ABNORMAL] = 1'b1;
               end
               if (op_fail && state == flash_writer_pkg::ST_PROG_BUSY) begin
                  next_return_code[flash_writer_pkg::BIT_PROGRAM_ERROR] = 1'b1;
               end
               if (op_fail && state == flash_writer_pkg::ST_ERASE_BUSY) begin
                  next_return_code[flash_writer_pkg::BIT_ERASE_ERROR] = 1'b1;
               end
               if (op_count_exceeded) begin
                  next_return_code[flash_writer_pkg::BIT_COUNT_EXCEEDED] = 1'b1;
               end
               if (addr_bad) begin
                  next_return_code[flash_writer_pkg::BIT_BAD_ADDRESS] = 1'b1;
               end
               next_state = flash_writer_pkg::ST_POLL;
            end
         end
         flash_writer_pkg::ST_ERASE_CONFIRM: begin
            if (write_pulse) begin
               if (cmd == flash_writer_pkg::CMD_AUTO_ERASE) begin
                  next_start = 1'b1;
                  next_erase = 1'b1;
                  // A stale program address flag must not taint the erase result
                  next_addr_bad = 1'b0;
                  next_state = flash_writer_pkg::ST_ERASE_BUSY;
               end else begin
                  next_return_code = error_code;
                  next_state = flash_writer_pkg::ST_CMD_WAIT;
               end
            end
         end
         flash_writer_pkg::ST_STATUS_CONFIRM: begin
            if (write_pulse) begin
               if (cmd == flash_writer_pkg::CMD_STATUS_READ) begin
                  next_state = flash_writer_pkg::ST_STATUS_READ;
               end else begin
                  next_return_code = error_code;
                  next_state = flash_writer_pkg::ST_CMD_WAIT;
               end
            end
         end
         default: begin
            if (idle_for_cmd && write_pulse) begin
               // Any command write ends the hold on the polling flags
               next_op_ended = 1'b0;
               next_op_normal = 1'b0;
               if (cmd != flash_writer_pkg::CMD_STATUS_READ) begin
                  next_return_code = flash_writer_pkg::RETURN_CODE_RESET;
               end
               case (cmd)
                  flash_writer_pkg::CMD_MEM_READ: begin
                     next_state = flash_writer_pkg::ST_MEM_READ;
                  end
                  flash_writer_pkg::CMD_AUTO_PROGRAM: begin
                     next_addr_bad = 1'b0;
                     next_byte_index = '0;
                     next_state = flash_writer_pkg::ST_PROG_ADDR;
                  end
                  flash_writer_pkg::CMD_AUTO_ERASE: begin
                     next_state = flash_writer_pkg::ST_ERASE_CONFIRM;
                  end
                  flash_writer_pkg::CMD_STATUS_READ: begin
                     next_state = flash_writer_pkg::ST_STATUS_CONFIRM;
                  end
                  default: begin
                     next_return_code = error_code;
                     next_state = flash_writer_pkg::ST_CMD_WAIT;
                  end
               endcase
            end
         end
      endcase
   end

   // Return code bits 2 and 3 are never set, so they always read zero
   always_comb begin
      read_byte = poll_byte(op_ended, op_normal);
      case (state)
         flash_writer_pkg::ST_MEM_READ: begin
            read_byte = mem_read_data;
         end
         flash_writer_pkg::ST_STATUS_READ: begin
            read_byte = return_code;
         end
         default: begin
            read_byte = poll_byte(op_ended, op_normal);
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= flash_writer_pkg::ST_OSC_SETTLE;
         wait_count <= '0;
      end else if (clk_en) begin
         state <= next_state;
         wait_count <= (next_state != state) ? 32'h0 : wait_count + 32'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         byte_index <= '0;
         return_code <= flash_writer_pkg::RETURN_CODE_RESET;
         op_ended <= 1'b0;
         op_normal <= 1'b0;
         addr_bad <= 1'b0;
         block_addr <= '0;
         array_op <= '0;
      end else if (clk_en) begin
         byte_index <= next_byte_index;
         return_code <= next_return_code;
         op_ended <= next_op_ended;
         op_normal <= next_op_normal;
         addr_bad <= next_addr_bad;
         block_addr <= next_block_addr;
         array_op <= '{start: next_start, erase: next_erase, block: next_block_addr};
      end
   end

   // Buffer has no reset; every byte is rewritten before each program start
   always_ff @(posedge sys_clk) begin
      if (clk_en && buf_write) begin
         block_buf[next_byte_index - IW'(1)] <= write_event.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         writer_data_bus_out <= flash_writer_pkg::DATA_RESET;
         writer_data_bus_oe <= 1'b0;
         mem_read_addr <= '0;
         block_read_data <= flash_writer_pkg::DATA_RESET;
      end else if (clk_en) begin
         writer_data_bus_out <= read_byte;
         writer_data_bus_oe <= read_enable && commands_ready && !busy;
         mem_read_addr <= writer_address_bus;
         block_read_data <= block_buf[block_read_index];
      end
   end

endmodule

// ===== dv/flash_writer_chk.sv
`timescale 1ns/1ps
module flash_writer_chk #(
   parameter int unsigned OSC_CYCLES = 20,
   parameter int unsigned SETUP_WAIT_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [flash_writer_pkg::DATA_W-1:0] writer_data_bus_out,
   input wire logic writer_data_bus_oe,
   input wire flash_writer_pkg::array_op_s array_op,
   input wire logic op_done,
   input wire logic op_fail,
   input wire logic op_count_exceeded,
   input wire logic commands_ready
);
   logic busy;
   logic fin_f;
   logic fail_f;
   int unsigned since_rst;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Poll flags are dropped on any write strobe, since a command write ends their life
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy <= 1'b0;
         fin_f <= 1'b0;
         fail_f <= 1'b0;
         since_rst <= 0;
      end else begin
         busy <= array_op.start ? 1'b1 : (op_done ? 1'b0 : busy);
         fin_f <= (busy && op_done) ? 1'b1 : ((!ce_n && !we_n) ? 1'b0 : fin_f);
         fail_f <= (busy && op_done) ? (op_fail || op_count_exceeded) :
                   ((!ce_n && !we_n) ? 1'b0 : fail_f);
         since_rst <= (since_rst < 32'd4000000) ? since_rst + 1 : since_rst;
      end
   end
   property p_ready_late;
      commands_ready |-> since_rst >= OSC_CYCLES + SETUP_WAIT_CYCLES - 1;
   endproperty
   a_ready_late: assert property (p_ready_late) else $error("ready too early");
   property p_ready_holds;
      commands_ready |=> commands_ready;
   endproperty
   a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
   property p_start_pulse;
      array_op.start |=> !array_op.start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_no_start_unready;
      array_op.start |-> commands_ready;
   endproperty
   a_no_start_unready: assert property (p_no_start_unready) else $error("start in startup");
   property p_busy_mute;
      busy |-> !writer_data_bus_oe;
   endproperty
   a_busy_mute: assert property (p_busy_mute) else $error("bus driven while busy");
   property p_oe_cause;
      writer_data_bus_oe |-> !$past(ce_n) && !$past(oe_n) && $past(we_n);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
   property p_read_drop;
      $rose(ce_n) |=> !writer_data_bus_oe;
   endproperty
   a_read_drop: assert property (p_read_drop) else $error("bus held after deselect");
   property p_done_flags;
      fin_f && writer_data_bus_oe |-> writer_data_bus_out[7] && writer_data_bus_out[5:0] == 6'h00;
   endproperty
   a_done_flags: assert property (p_done_flags) else $error("bad finished poll byte");
   property p_fail_flags;
      fail_f && writer_data_bus_oe |-> writer_data_bus_out == 8'h80;
   endproperty
   a_fail_flags: assert property (p_fail_flags) else $error("bad failed poll byte");
endmodule
bind flash_writer_mode flash_writer_chk #(.OSC_CYCLES(OSC_CYCLES),
   .SETUP_WAIT_CYCLES(SETUP_WAIT_CYCLES)) u_chk (.sys_clk(sys_clk), .srst(srst), .ce_n(ce_n),
   .oe_n(oe_n), .we_n(we_n), .writer_data_bus_out(writer_data_bus_out),
   .writer_data_bus_oe(writer_data_bus_oe), .array_op(array_op), .op_done(op_done),
   .op_fail(op_fail), .op_count_exceeded(op_count_exceeded), .commands_ready(commands_ready));

// ===== dv/flash_back_model.sv
`timescale 1ns/1ps
module flash_back_model #(
   parameter int DONE_DELAY = 200
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire flash_writer_pkg::array_op_s array_op,
   input wire logic [17:0] mem_read_addr,
   output logic [7:0] mem_read_data,
   output logic [6:0] block_read_index = 7'h00,
   input wire logic [7:0] block_read_data,
   output logic op_done = 1'b0,
   output logic op_fail = 1'b0,
   output logic op_count_exceeded = 1'b0,
   input wire logic fail_req,
   input wire logic count_req
);
   logic run = 1'b0;
   logic erase_q = 1'b0;
   logic [10:0] block_q = 11'h000;
   int cnt = 0;
   logic [7:0] buf_q [128];
   // Array content is a pattern of the address, so any read can be predicted
   assign mem_read_data = mem_read_addr[7:0] ^ 8'hA5;
   always @(posedge sys_clk) begin
      op_done <= !srst && !array_op.start && run && cnt == DONE_DELAY;
      if (srst) begin
         run <= 1'b0;
      end else if (array_op.start) begin
         run <= 1'b1;
         cnt <= 0;
         erase_q <= array_op.erase;
         block_q <= array_op.block;
         block_read_index <= 7'h00;
      end else if (run) begin
         cnt <= cnt + 1;
         if (cnt < 127) block_read_index <= 7'(cnt + 1);
         if (cnt >= 1 && cnt <= 128) buf_q[cnt-1] <= block_read_data;
         if (cnt == DONE_DELAY) begin
            op_fail <= fail_req;
            op_count_exceeded <= count_req;
            run <= 1'b0;
         end
      end
   end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
   logic sys_clk, srst, clk_en, ce_n, oe_n, we_n, op_done, op_fail, op_count_exceeded;
   logic writer_data_bus_oe, commands_ready, fail_req, count_req;
   logic [17:0] writer_address_bus, mem_read_addr;
   logic [7:0] writer_data_bus_in, writer_data_bus_out, mem_read_data, block_read_data;
   logic [6:0] block_read_index;
   flash_writer_pkg::array_op_s array_op;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int k;
   flash_writer_mode #(.OSC_CYCLES(20), .SETUP_WAIT_CYCLES(20)) u_dut (.sys_clk, .srst,
      .clk_en, .ce_n, .oe_n, .we_n, .writer_address_bus, .writer_data_bus_in,
      .writer_data_bus_out, .writer_data_bus_oe, .mem_read_addr, .mem_read_data, .array_op,
      .block_read_index, .block_read_data, .op_done, .op_fail, .op_count_exceeded,
      .commands_ready);
   flash_back_model #(.DONE_DELAY(200)) u_back (.sys_clk, .srst, .array_op, .mem_read_addr,
      .mem_read_data, .block_read_index, .block_read_data, .op_done, .op_fail,
      .op_count_exceeded, .fail_req, .count_req);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Counts: %0d compared, %0d mismatched", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Data is inverted after the strobe so a late capture cannot pass by luck
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      ce_n <= 1'b0;
      we_n <= 1'b0;
      writer_address_bus <= a;
      writer_data_bus_in <= d;
      @(posedge sys_clk);
      ce_n <= 1'b1;
      we_n <= 1'b1;
      writer_data_bus_in <= ~d;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic rd_chk(input logic [17:0] a, input logic [7:0] exp, input logic [7:0] mask);
      @(posedge sys_clk);
      ce_n <= 1'b0;
      oe_n <= 1'b0;
      writer_address_bus <= a;
      repeat (4) @(posedge sys_clk);
      #1;
      chk(18'(writer_data_bus_oe), 18'h1);
      chk(18'(writer_data_bus_out & mask), 18'(exp & mask));
      @(posedge sys_clk);
      ce_n <= 1'b1;
      oe_n <= 1'b1;
   endtask
   task automatic cmd2(input logic [7:0] c);
      wr(18'h0, c);
      wr(18'h0, c);
   endtask
   // No writes while busy; a finish that never comes counts as a mismatch
   task automatic wait_done();
      for (int i = 0; i < 400 && op_done !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(18'(op_done), 18'h1);
      repeat (3) @(posedge sys_clk);
   endtask
   // Block address goes only with the first data byte; later bytes repeat it unchanged
   task automatic prog(input logic [17:0] base);
      wr(18'h0, flash_writer_pkg::CMD_AUTO_PROGRAM);
      for (int j = 0; j < 128; j++) wr(base, 8'(j) ^ 8'h3C);
      wait_done();
   endtask
   // Traffic is about 2800 cycles; the ceiling leaves wide room
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      srst = 1'b1;
      clk_en = 1'b1;
      {ce_n, oe_n, we_n} = 3'b111;
      writer_address_bus = 18'h0;
      writer_data_bus_in = 8'h00;
      {fail_req, count_req} = 2'b00;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      #1;
      chk(18'(commands_ready), 18'h0);
      for (int i = 0; i < 100 && commands_ready !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(18'(commands_ready), 18'h1);
      rd_chk(18'h00012, 8'h12 ^ 8'hA5, 8'hFF);
      $display("test startup done");
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'h00, 8'hF3);
      $display("test initial code done");
      prog(18'h00100);
      chk(18'(u_back.block_q), 18'h002);
      chk(18'(u_back.erase_q), 18'h0);
      for (k = 0; k < 128; k++) chk(18'(u_back.buf_q[k]), 18'(8'(k) ^ 8'h3C));
      rd_chk(18'h0, 8'hC0, 8'hFF);
      rd_chk(18'h0, 8'hC0, 8'hFF);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'h00, 8'hF3);
      $display("test program done");
      prog(18'h00240);
      rd_chk(18'h0, 8'h80, 8'hFF);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'h81, 8'hF3);
      rd_chk(18'h0, 8'h81, 8'hF3);
      $display("test bad address done");
      fail_req <= 1'b1;
      cmd2(flash_writer_pkg::CMD_AUTO_ERASE);
      wait_done();
      chk(18'(u_back.erase_q), 18'h1);
      rd_chk(18'h0, 8'h80, 8'hFF);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'h90, 8'hF3);
      $display("test erase fail done");
      count_req <= 1'b1;
      prog(18'h00380);
      rd_chk(18'h0, 8'h80, 8'hFF);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'hA2, 8'hF3);
      {fail_req, count_req} <= 2'b00;
      $display("test program fail done");
      wr(18'h0, 8'h55);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'hC0, 8'hF3);
      wr(18'h0, flash_writer_pkg::CMD_AUTO_ERASE);
      wr(18'h0, 8'h21);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'hC0, 8'hF3);
      wr(18'h0, flash_writer_pkg::CMD_MEM_READ);
      rd_chk(18'h00077, 8'h77 ^ 8'hA5, 8'hFF);
      wr(18'h0, flash_writer_pkg::CMD_STATUS_READ);
      wr(18'h0, 8'h70);
      cmd2(flash_writer_pkg::CMD_STATUS_READ);
      rd_chk(18'h0, 8'hC0, 8'hF3);
      $display("test command error done");
      cmd2(flash_writer_pkg::CMD_AUTO_ERASE);
      wait_done();
      rd_chk(18'h0, 8'hC0, 8'hFF);
      $display("test erase done");
      print_verdict();
   end
endmodule
